// ---- src/uart_core_defs.vh ----
// constants for the serial transceiver core
`ifndef UART_CORE_DEFS_VH
`define UART_CORE_DEFS_VH
`define ADDR_STATUS      3'h0
`define ADDR_DATA        3'h1
`define ADDR_CTRL_ONE    3'h2
`define ADDR_CTRL_TWO    3'h3
`define ADDR_BAUD_LOW    3'h4
`define ADDR_BAUD_HIGH   3'h5
`define ADDR_FIFO_CTRL   3'h6
// control one bits
`define C1_GLOBAL_EN     7
`define C1_WORD9         6
`define C1_PAR_EN        5
`define C1_PAR_T1        4
`define C1_PAR_T0        3
`define C1_STOP2         2
`define C1_TX9           1
`define C1_RX9           0
// control two bits
`define C2_TX_EN         7
`define C2_RX_EN         6
`define C2_BREAK         5
`define C2_ADDR_DET      4
`define C2_TE_IE         3
// status bits
`define ST_OVERRUN       7
`define ST_NOISE         6
`define ST_FRAMING       5
`define ST_PARITY        4
`define ST_TX_IDLE       3
`define ST_TX_EMPTY      2
`define ST_RX_IDLE       1
`define ST_RX_READY      0
// parity types
`define PAR_EVEN         2'h0
`define PAR_ODD          2'h1
`define PAR_MARK         2'h2
`define PAR_SPACE        2'h3
`define CTRL_ONE_RST     8'h00
`define CTRL_TWO_RST     8'h00
`define BREAK_BITS       4'hd
`endif

// ---- src/uart_frame_tx_rx_core.v ----
// serial transceiver core: framing, baud timing, transmit and receive paths
//
// Behaviour
// - nrz frame: one start bit, 8 or 9 data bits, one or two stop bits
// - parity even, odd, mark, space or off via enable and two-bit type
// - reset format is eight data bits, no parity, one stop bit
// - one format and 16-bit baud divider shared; both directions lsb first
// - transmit line rests high when enabled and idle
// - global disable releases pins and empties the data buffer
// - global disable clears transmit/receive enables, break, receive flags, count; sets idle/empty flags
// - disable aborts transfers at once; other settings kept
// - word-length bit gives nine data bits from and into dedicated bits
// - with address detection the top data bit marks an address frame
// - stop count applies to transmit only; receiver checks one stop bit
// - shift register reloads only after previous stop bit is out
// - transmission starts when enable set and holding register full, either order
// - clearing transmit enable mid-frame drives output high and resets transmitter
// - data writes are blocked while transmit-empty flag is zero
// - status access then data write clears transmit-empty and transmit-idle
// - transmit-empty set when data register can accept; irq when enabled
// - write while idle goes straight to shifter; write in frame waits
// - transmit-idle set when a frame or break frame completes
// - break request held over brd+1 clocks while idle sends 14 zero-bit break (start bit plus 13)
// - held break repeats with no irq; on clear finish break then stop bits
// - bit timing counted in system clocks, three-sample majority, word moved when register has room
// - bit time is brd clocks plus one when fraction accumulator carries
// - sample points brd/2,+1,+2 or brd/2-1,brd/2,+2 by range select
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "uart_core_defs.vh"
module uart_frame_tx_rx_core (
  input  wire       clk,           // 20 mhz system clock
  input  wire       sys_rst,       // async reset, active high
  input  wire [2:0] reg_addr,      // register address
  input  wire [7:0] reg_wdata,     // write data
  input  wire       reg_wr,        // write strobe
  input  wire       reg_rd,        // read strobe
  output reg  [7:0] reg_rdata,     // read data, cycle after strobe
  input  wire       rx_pin,        // serial input from remote
  output reg        tx_pin,        // serial output
  output reg        tx_pin_oe,     // high while core owns tx pin
  output reg        rx_pin_owned,  // high while core owns rx pin
  output reg        irq            // transmit-empty request
);
  reg [7:0]  uart_control_one_q;
  reg [7:0]  uart_control_two_q;
  reg [7:0]  baud_divider_low_q;
  reg [7:0]  baud_divider_high_q;
  reg [5:0]  fifo_control_register_q;
  reg        transmit_empty_flag_q, transmit_idle_flag_q, receive_ready_flag_q;
  reg        overrun_flag_q, framing_flag_q, parity_flag_q, noise_flag_q, receive_idle_flag_q;
  reg        status_seen_q, address_frame_q;
  reg [8:0]  serial_data_register_q;
  reg        hold_full_q;
  reg [8:0]  rx_data_q;
  reg [2:0]  receive_byte_count_q;

  wire        uart_global_enable    = uart_control_one_q[`C1_GLOBAL_EN];
  wire        word_length_select    = uart_control_one_q[`C1_WORD9];
  wire        parity_enable         = uart_control_one_q[`C1_PAR_EN];
  wire [1:0]  parity_type_field     = uart_control_one_q[`C1_PAR_T1:`C1_PAR_T0];
  wire        stop_bit_count_select = uart_control_one_q[`C1_STOP2];
  wire        transmit_ninth_bit    = uart_control_one_q[`C1_TX9];
  wire        transmit_enable       = uart_control_two_q[`C2_TX_EN];
  wire        receive_enable        = uart_control_two_q[`C2_RX_EN];
  wire        break_request         = uart_control_two_q[`C2_BREAK];
  wire        address_detect        = uart_control_two_q[`C2_ADDR_DET];
  wire        transmit_empty_irq_enable = uart_control_two_q[`C2_TE_IE];
  wire [15:0] brd                   = {baud_divider_high_q, baud_divider_low_q};
  wire [2:0]  baud_fraction_field   = fifo_control_register_q[5:3];
  wire        divider_range_select  = fifo_control_register_q[2];
  wire        tx_on                 = uart_global_enable & transmit_enable;
  wire        rx_on                 = uart_global_enable & receive_enable;
  wire [3:0]  nbits                 = word_length_select ? 4'h9 : 4'h8;

  // parity of a data word for the chosen type
  function par_bit(input [8:0] d, input w9, input [1:0] t);
    reg x;
    begin
      x = ^(d[7:0]) ^ (w9 & d[8]);
      case (t)
        `PAR_EVEN: par_bit = x;
        `PAR_ODD:  par_bit = ~x;
        `PAR_MARK: par_bit = 1'b1;
        default:   par_bit = 1'b0;
      endcase
    end
  endfunction

  // register writes and software sequences
  wire wr_data  = reg_wr & (reg_addr == `ADDR_DATA);
  wire acc_stat = (reg_wr | reg_rd) & (reg_addr == `ADDR_STATUS);
  wire rd_data  = reg_rd & (reg_addr == `ADDR_DATA);
  wire data_ok  = wr_data & transmit_empty_flag_q;
  wire tx_clear = data_ok & status_seen_q;

  // transmitter
  localparam TS_IDLE = 3'h0, TS_START = 3'h1, TS_DATA = 3'h2, TS_PAR = 3'h3, TS_STOP = 3'h4, TS_BRK = 3'h5;
  reg [2:0]  ts_q;
  reg [15:0] tcnt_q;
  reg [2:0]  tacc_q;
  reg [8:0]  transmit_shift_register_q;
  reg [3:0]  tbit_q;
  reg [3:0]  brk_left_q;
  reg        stop2_q, brk_frame_q;
  reg [16:0] brk_hold_q;
  wire       brk_armed = (brk_hold_q > ({1'b0, brd} + 17'h0_0001));
  wire [3:0] tsum      = {1'b0, tacc_q} + {1'b0, baud_fraction_field};
  wire [15:0] tlen     = brd + {15'h0000, tsum[3]};
  wire       tbit_end  = (tcnt_q + 16'h0001 >= tlen);
  wire       tx_start_now = (ts_q == TS_IDLE) & tx_on & (hold_full_q | data_ok | brk_armed);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ts_q <= TS_IDLE;
      tcnt_q <= 16'h0000;
      tacc_q <= 3'h0;
      transmit_shift_register_q <= 9'h000;
      tbit_q <= 4'h0;
      brk_left_q <= 4'h0;
      stop2_q <= 1'b0;
      brk_frame_q <= 1'b0;
      brk_hold_q <= 17'h0_0000;
      tx_pin <= 1'b1;
    end else begin
      if (break_request & transmit_idle_flag_q & ~brk_armed)
        brk_hold_q <= brk_hold_q + 17'h0_0001;
      else if (~break_request)
        brk_hold_q <= 17'h0_0000;
      if (~tx_on) begin
        ts_q <= TS_IDLE;
        tx_pin <= 1'b1;
        tcnt_q <= 16'h0000;
        tacc_q <= 3'h0;
        brk_hold_q <= 17'h0_0000;
      end else if (tx_start_now) begin
        ts_q <= TS_START;
        tx_pin <= 1'b0;
        tcnt_q <= 16'h0000;
        tacc_q <= 3'h0;
        brk_frame_q <= brk_armed & ~(hold_full_q | data_ok);
        transmit_shift_register_q <= hold_full_q ? serial_data_register_q
                                                 : {transmit_ninth_bit, reg_wdata};
      end else if (ts_q != TS_IDLE) begin
        if (!tbit_end)
          tcnt_q <= tcnt_q + 16'h0001;
        else begin
          tcnt_q <= 16'h0000;
          tacc_q <= tsum[2:0];
          case (ts_q)
            TS_START: begin
              tbit_q <= 4'h0;
              if (brk_frame_q) begin
                ts_q <= TS_BRK;
                brk_left_q <= `BREAK_BITS - 4'h1;
                tx_pin <= 1'b0;
              end else begin
                ts_q <= TS_DATA;
                tx_pin <= transmit_shift_register_q[0];
              end
            end
            TS_DATA: begin
              if (tbit_q + 4'h1 < nbits) begin
                tbit_q <= tbit_q + 4'h1;
                tx_pin <= transmit_shift_register_q[tbit_q + 4'h1];
              end else if (parity_enable) begin
                ts_q <= TS_PAR;
                tx_pin <= par_bit(transmit_shift_register_q, word_length_select, parity_type_field);
              end else begin
                ts_q <= TS_STOP;
                tx_pin <= 1'b1;
                stop2_q <= stop_bit_count_select;
              end
            end
            TS_PAR: begin
              ts_q <= TS_STOP;
              tx_pin <= 1'b1;
              stop2_q <= stop_bit_count_select;
            end
            TS_BRK: begin
              if (brk_left_q != 4'h0)
                brk_left_q <= brk_left_q - 4'h1;
              else if (break_request)
                brk_left_q <= `BREAK_BITS - 4'h1;
              else begin
                ts_q <= TS_STOP;
                tx_pin <= 1'b1;
                stop2_q <= stop_bit_count_select;
              end
            end
            TS_STOP: begin
              if (stop2_q)
                stop2_q <= 1'b0;
              else begin
                ts_q <= TS_IDLE;
                tx_pin <= 1'b1;
              end
            end
            default: ts_q <= TS_IDLE;
          endcase
        end
      end
    end
  end
  wire tx_frame_done = tx_on & (ts_q == TS_STOP) & tbit_end & ~stop2_q;

  // receiver: two-flop synchroniser then fixed sample points
  localparam RS_IDLE = 2'h0, RS_BITS = 2'h1, RS_WAIT = 2'h2;
  reg        rx_s1_q, rx_s2_q, rx_prev_q;
  reg [1:0]  rs_q;
  reg [15:0] rcnt_q;
  reg [2:0]  racc_q;
  reg [3:0]  rbit_q;
  reg [2:0]  smp_q;
  reg [10:0] receive_shift_register_q;
  reg        rnoise_q;
  wire [3:0]  rsum   = {1'b0, racc_q} + {1'b0, baud_fraction_field};
  wire [15:0] rlen   = brd + {15'h0000, rsum[3]};
  wire [15:0] half   = {1'b0, brd[15:1]};
  wire [15:0] sp0    = divider_range_select ? half - 16'h0001 : half;
  wire [15:0] sp1    = divider_range_select ? half : half + 16'h0001;
  wire [15:0] sp2    = half + 16'h0002;
  wire        vote   = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  wire        noisy  = ~(smp_q[0] == smp_q[1] && smp_q[1] == smp_q[2]);
  wire        rbit_end = (rcnt_q + 16'h0001 >= rlen);
  wire [3:0]  rlast  = nbits + {3'h0, parity_enable};                      // one stop
  wire        rx_done = rx_on & (rs_q == RS_BITS) & rbit_end & (rbit_q == rlast + 4'h1);
  wire [10:0] rword  = {vote, receive_shift_register_q[10:1]};
  wire [8:0]  rdat   = parity_enable ? (word_length_select ? rword[8:0] : {1'b0, rword[8:1]})
                                     : (word_length_select ? rword[9:1] : {1'b0, rword[9:2]});
  // parity always sits just below the stop bit, whatever the word length
  wire        rpar   = rword[9];
  wire        r_store = rx_done & (~receive_ready_flag_q | rd_data);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
      rs_q <= RS_IDLE;
      rcnt_q <= 16'h0000;
      racc_q <= 3'h0;
      rbit_q <= 4'h0;
      smp_q <= 3'h7;
      receive_shift_register_q <= 11'h000;
      rnoise_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
      if (~rx_on) begin
        rs_q <= RS_IDLE;
        rcnt_q <= 16'h0000;
      end else case (rs_q)
        RS_IDLE: if (rx_prev_q & ~rx_s2_q) begin
          rs_q <= RS_BITS;
          rcnt_q <= 16'h0001;
          racc_q <= 3'h0;
          rbit_q <= 4'h0;
          rnoise_q <= 1'b0;
        end
        RS_BITS: begin
          if (rcnt_q == sp0) smp_q[0] <= rx_s2_q;
          if (rcnt_q == sp1) smp_q[1] <= rx_s2_q;
          if (rcnt_q == sp2) smp_q[2] <= rx_s2_q;
          if (!rbit_end)
            rcnt_q <= rcnt_q + 16'h0001;
          else begin
            rcnt_q <= 16'h0000;
            racc_q <= rsum[2:0];
            rnoise_q <= rnoise_q | noisy;
            receive_shift_register_q <= rword;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h0 && vote)
              rs_q <= RS_IDLE;
            else if (rx_done)
              rs_q <= vote ? RS_IDLE : RS_WAIT;
          end
        end
        RS_WAIT: if (rx_s2_q) rs_q <= RS_IDLE;
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  // registers, flags and read path
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uart_control_one_q <= `CTRL_ONE_RST;
      uart_control_two_q <= `CTRL_TWO_RST;
      baud_divider_low_q <= 8'h00;
      baud_divider_high_q <= 8'h00;
      fifo_control_register_q <= 6'h00;
      transmit_empty_flag_q <= 1'b1;
      transmit_idle_flag_q <= 1'b1;
      receive_ready_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      framing_flag_q <= 1'b0;
      parity_flag_q <= 1'b0;
      noise_flag_q <= 1'b0;
      receive_idle_flag_q <= 1'b1;
      status_seen_q <= 1'b0;
      address_frame_q <= 1'b0;
      serial_data_register_q <= 9'h000;
      hold_full_q <= 1'b0;
      rx_data_q <= 9'h000;
      receive_byte_count_q <= 3'h0;
      reg_rdata <= 8'h00;
      tx_pin_oe <= 1'b0;
      rx_pin_owned <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_CTRL_ONE:  uart_control_one_q <= {reg_wdata[7:1], uart_control_one_q[0]};
          `ADDR_CTRL_TWO:  uart_control_two_q <= reg_wdata;
          `ADDR_BAUD_LOW:  baud_divider_low_q <= reg_wdata;
          `ADDR_BAUD_HIGH: baud_divider_high_q <= reg_wdata;
          `ADDR_FIFO_CTRL: fifo_control_register_q <= reg_wdata[5:0];
          default: ;
        endcase
      end
      if (acc_stat)
        status_seen_q <= 1'b1;
      else if (wr_data | rd_data)
        status_seen_q <= 1'b0;
      // transmit holding register
      if (tx_start_now & hold_full_q)
        hold_full_q <= data_ok;
      else if (data_ok & ~tx_start_now) begin
        serial_data_register_q <= {transmit_ninth_bit, reg_wdata};
        hold_full_q <= 1'b1;
      end
      if (tx_start_now & hold_full_q & data_ok)
        serial_data_register_q <= {transmit_ninth_bit, reg_wdata};
      // set wins over clear for hardware-set flags
      if (tx_start_now & ~(hold_full_q & data_ok))
        transmit_empty_flag_q <= 1'b1;
      else if (tx_clear | (data_ok & hold_full_q))
        transmit_empty_flag_q <= 1'b0;
      if (tx_frame_done)
        transmit_idle_flag_q <= 1'b1;
      else if (tx_clear)
        transmit_idle_flag_q <= 1'b0;
      // receive side
      receive_idle_flag_q <= (rs_q != RS_BITS);
      if (r_store) begin
        rx_data_q <= vote ? rdat : 9'h000;
        uart_control_one_q[`C1_RX9] <= vote ? rdat[8] : 1'b0;
        address_frame_q <= address_detect & (word_length_select ? rdat[8] : rdat[7]);
        receive_ready_flag_q <= 1'b1;
        framing_flag_q <= ~vote;
        parity_flag_q <= parity_enable & (rpar != par_bit(rdat, word_length_select, parity_type_field));
        noise_flag_q <= rnoise_q | noisy;
        receive_byte_count_q <= 3'h1;
      end else if (rd_data & status_seen_q) begin
        receive_ready_flag_q <= 1'b0;
        overrun_flag_q <= 1'b0;
        noise_flag_q <= 1'b0;
        receive_byte_count_q <= 3'h0;
      end
      if (rx_done & ~r_store)
        overrun_flag_q <= 1'b1;
      if (~uart_global_enable) begin
        uart_control_two_q[`C2_TX_EN] <= 1'b0;
        uart_control_two_q[`C2_RX_EN] <= 1'b0;
        uart_control_two_q[`C2_BREAK] <= 1'b0;
        hold_full_q <= 1'b0;
        receive_ready_flag_q <= 1'b0;
        overrun_flag_q <= 1'b0;
        framing_flag_q <= 1'b0;
        parity_flag_q <= 1'b0;
        noise_flag_q <= 1'b0;
        receive_byte_count_q <= 3'h0;
        transmit_empty_flag_q <= 1'b1;
        transmit_idle_flag_q <= 1'b1;
        receive_idle_flag_q <= 1'b1;
      end
      tx_pin_oe <= tx_on;
      rx_pin_owned <= rx_on;
      irq <= transmit_empty_irq_enable & transmit_empty_flag_q & tx_on & ~break_request
             & ~(brk_frame_q & (ts_q != TS_IDLE));
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_STATUS:    reg_rdata <= {overrun_flag_q, noise_flag_q, framing_flag_q, parity_flag_q,
                                         transmit_idle_flag_q, transmit_empty_flag_q,
                                         receive_idle_flag_q, receive_ready_flag_q};
          `ADDR_DATA:      reg_rdata <= rx_data_q[7:0];
          `ADDR_CTRL_ONE:  reg_rdata <= uart_control_one_q;
          `ADDR_CTRL_TWO:  reg_rdata <= uart_control_two_q;
          `ADDR_BAUD_LOW:  reg_rdata <= baud_divider_low_q;
          `ADDR_BAUD_HIGH: reg_rdata <= baud_divider_high_q;
          `ADDR_FIFO_CTRL: reg_rdata <= {2'b00, fifo_control_register_q};
          default:         reg_rdata <= {address_frame_q, 4'h0, receive_byte_count_q};
        endcase
      end
    end
  end
endmodule

// ---- verif/uart_frame_tx_rx_core_asserts.sv ----
// port-level checks for the serial transceiver core
`timescale 1ns/100ps
`include "uart_core_defs.vh"
module uart_core_asserts (
  input wire       clk,          // clock
  input wire       sys_rst,      // async reset
  input wire [2:0] reg_addr,     // address
  input wire [7:0] reg_wdata,    // write data
  input wire       reg_wr,       // write strobe
  input wire       reg_rd,       // read strobe
  input wire [7:0] reg_rdata,    // read data
  input wire       rx_pin,       // serial in
  input wire       tx_pin,       // serial out
  input wire       tx_pin_oe,    // tx pin owned
  input wire       rx_pin_owned, // rx pin owned
  input wire       irq           // tx empty request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_len: assert property ($fell(tx_pin) |-> ##1 (!tx_pin || !tx_pin_oe) [*8])
    else $error("start bit too short");
  a_oe_release: assert property ($fell(tx_pin_oe) |-> ##[0:1] tx_pin)
    else $error("tx line not idle after release");
  a_irq_oe: assert property ($rose(irq) |-> tx_pin_oe)
    else $error("irq without transmitter");
  a_irq_drop: assert property ($fell(tx_pin_oe) |-> ##[0:2] !irq)
    else $error("irq kept after transmitter off");
  a_baud_keep: assert property (reg_wr && reg_addr == `ADDR_BAUD_LOW ##1 !reg_wr ##1 reg_rd && reg_addr == `ADDR_BAUD_LOW |=> reg_rdata == $past(reg_wdata, 3))
    else $error("baud low readback wrong");
  a_tx_off: assert property (reg_wr && reg_addr == `ADDR_CTRL_TWO && !reg_wdata[`C2_TX_EN] |-> ##[1:3] !tx_pin_oe)
    else $error("tx pin kept after disable");
  a_rx_off: assert property (reg_wr && reg_addr == `ADDR_CTRL_TWO && !reg_wdata[`C2_RX_EN] |-> ##[1:3] !rx_pin_owned)
    else $error("rx pin kept after disable");
  a_global_off: assert property (reg_wr && reg_addr == `ADDR_CTRL_ONE && !reg_wdata[`C1_GLOBAL_EN] |-> ##[1:3] (!tx_pin_oe && !rx_pin_owned))
    else $error("pins kept after global disable");
  c_tx_frame: cover property ($fell(tx_pin));
  c_irq: cover property ($rose(irq));
  c_rx_off: cover property ($fell(rx_pin_owned));
endmodule
bind uart_frame_tx_rx_core uart_core_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
  .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .rx_pin_owned(rx_pin_owned), .irq(irq));

// ---- verif/uart_remote_model.sv ----
// remote serial partner: drives the core receive line, samples its transmit line
`timescale 1ns/100ps
module uart_remote_model #(
  parameter integer BT = 16 // clocks per bit
) (
  input  wire clk,      // clock
  input  wire line_in,  // core transmit line
  output reg  line_out  // core receive line
);
  initial line_out = 1'b1;
  // bit 0 is the start bit; one stop bit is enough for the receiver
  task send(input [15:0] f, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        line_out <= f[j];
        repeat (BT) @(posedge clk);
      end
      line_out <= 1'b1;
    end
  endtask
  // returns at mid last bit so a back-to-back start edge is not missed
  task take(output [15:0] f, input integer n);
    integer j;
    begin
      f = 16'hFFFF;
      @(negedge line_in);
      repeat (BT / 2) @(posedge clk);
      for (j = 0; j < n; j = j + 1) begin
        if (j > 0)
          repeat (BT) @(posedge clk);
        f[j] = line_in;
      end
    end
  endtask
endmodule

// ---- verif/uart_frame_tx_rx_core_tb.sv ----
// self-checking bench for the serial transceiver core
`timescale 1ns/100ps
module uart_frame_tx_rx_core_tb;
  localparam integer BT = 16;
  localparam [55:0] FMTS = 56'hC4_C2B8_B0AC_A080;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [2:0]  reg_addr = 3'h0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [7:0]  reg_rdata;
  wire        rx_pin, tx_pin, tx_pin_oe, rx_pin_owned, irq;
  integer     n_fail = 0, n_compared = 0, seed = 54935, i, k;
  reg  [7:0]  c, s;
  reg  [8:0]  w;
  reg  [15:0] got;
  reg  [15:0] exp_q[$];
  always #25 clk = ~clk;
  uart_frame_tx_rx_core dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_pin_oe(tx_pin_oe), .rx_pin_owned(rx_pin_owned), .irq(irq));
  uart_remote_model #(.BT(BT)) model_u (.clk(clk), .line_in(tx_pin), .line_out(rx_pin));
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
    end
  endtask
  task rc(input [2:0] a, input [7:0] e);
    begin
      rd(a, s);
      chk({8'h00, s}, {8'h00, e});
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  function integer nb(input [7:0] f);
    nb = 10 + f[6] + f[5] + f[2];
  endfunction
  // expected line bits: start, data lsb first, parity, stop bits left high
  function [15:0] frm(input [8:0] d, input [7:0] f);
    integer j, nd;
    reg p;
    begin
      nd = f[6] ? 9 : 8;
      frm = 16'hFFFF;
      frm[0] = 1'b0;
      p = 1'b0;
      for (j = 0; j < nd; j = j + 1) begin
        frm[j + 1] = d[j];
        p = p ^ d[j];
      end
      if (f[5])
        frm[nd + 1] = (f[4:3] == 2'h0) ? p : (f[4:3] == 2'h1) ? !p : !f[3];
    end
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rc(3'h0, 8'h0E);
    rc(3'h2, 8'h00);
    rc(3'h7, 8'h00);
    wr(3'h4, BT[7:0]);
    rc(3'h4, BT[7:0]);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h80);
    wr(3'h3, 8'hC8);
    repeat (4) @(posedge clk);
    chk({12'h0, tx_pin, irq, tx_pin_oe, rx_pin_owned}, 16'h000F);
    $display("setup done");
    for (i = 0; i < 7; i = i + 1) begin
      c = FMTS[i * 8 +: 8];
      w = 9'($random(seed));
      wr(3'h2, c);
      fork
        model_u.take(got, nb(c));
        begin
          rd(3'h0, s);
          wr(3'h1, w[7:0]);
        end
      join
      chk(got, frm({c[1], w[7:0]}, c));
      repeat (3 * BT) @(posedge clk);
    end
    $display("tx formats done");
    wr(3'h2, 8'h80);
    fork
      for (k = 0; k < 2; k = k + 1) begin
        model_u.take(got, 10);
        chk(got, exp_q.pop_front());
      end
      for (i = 0; i < 3; i = i + 1) begin
        w = 9'($random(seed));
        if (i < 2)
          rd(3'h0, s);
        wr(3'h1, w[7:0]);
        if (i < 2)
          exp_q.push_back(frm({1'b0, w[7:0]}, 8'h80));
      end
    join
    repeat (BT) @(posedge clk);
    chk({15'h0, tx_pin}, 16'h0001);
    repeat (2 * BT) @(posedge clk);
    rc(3'h0, 8'h0E);
    $display("holding test done");
    rd(3'h0, s);
    wr(3'h1, 8'h00);
    repeat (3 * BT) @(posedge clk);
    wr(3'h3, 8'h08);
    repeat (4) @(posedge clk);
    chk({13'h0, tx_pin, tx_pin_oe, rx_pin_owned}, 16'h0004);
    $display("abort test done");
    wr(3'h3, 8'hD8);
    for (k = 0; k < 3; k = k + 1) begin
      c = (k == 2) ? 8'hA0 : k ? 8'hC0 : 8'h80;
      w = 9'($random(seed));
      wr(3'h2, c);
      wr(3'h6, (k == 2) ? 8'h04 : 8'h00);
      model_u.send(frm(w, c), nb(c));
      // the receiver finishes the stop bit a few clocks after the line does
      repeat (4) @(posedge clk);
      rd(3'h0, s);
      chk({8'h00, s & 8'hF1}, 16'h0001);
      rc(3'h7, {(k == 1) ? w[8] : w[7], 7'h01});
      rc(3'h1, w[7:0]);
      rd(3'h2, s);
      if (k == 1)
        chk({15'h0, s[0]}, {15'h0, w[8]});
    end
    $display("receive test done");
    wr(3'h3, 8'hF8);
    wr(3'h2, 8'h04);
    rc(3'h3, 8'h18);
    rc(3'h0, 8'h0E);
    rc(3'h4, BT[7:0]);
    rc(3'h6, 8'h04);
    rd(3'h2, s);
    chk({8'h00, s & 8'hFE}, 16'h0004);
    $display("disable test done");
    results;
  end
endmodule
